// [rtl/vid_reference_slew_control.sv]
// reference update logic driven by the voltage identification inputs
// Summary of operation
// - six-bit mode samples inputs six times per cycle
// - six-bit code accepted after three identical samples
// - six-bit mode jumps target straight to code
// - five-bit modes accept multi-step code changes
// - five-bit: wait half cycle, step each cycle
// - latency up to one cycle plus slewing
// - off codes shut down, other codes restart
// - two cycles before shutdown trip level, pwm off
`timescale 1ns/1ps
`include "vrsc_cfg.svh"

module vid_reference_slew_control
    import vrsc_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [4:0] voltage_id_inputs,
    input wire logic half_step_select_bit,
    input wire logic [1:0] dac_mode_sel,
    output logic [7:0] dac_target_voltage,
    output logic pwm_enable,
    output logic ovp_shutdown_level,
    output logic slew_busy,
    output logic [5:0] accepted_code
);

    ////////////////////////////////////////////////////////////////////////
    // decode functions

    function automatic vrsc_mode_t mode_of(input logic [1:0] sel);
        vrsc_mode_t m;
        m = VRSC_MODE_SIX;
        if (sel == 2'h1) begin
            m = VRSC_MODE_FIVE_HI;
        end else if (sel == 2'h2) begin
            m = VRSC_MODE_FIVE_LO;
        end
        return m;
    endfunction

    function automatic logic is_off(input vrsc_mode_t m, input logic [5:0] c);
        logic r;
        r = (m == VRSC_MODE_SIX) ? (c[5:1] == `VRSC_OFF_VID) : (c[4:0] == `VRSC_OFF_VID);
        return r;
    endfunction

    // code to a count of 12.5mV units
    function automatic logic [7:0] code_units(input vrsc_mode_t m, input logic [5:0] c);
        logic [5:0] d;
        logic [7:0] u;
        d = `VRSC_SIX_ORIGIN - c;
        u = `VRSC_SIX_BASE + {2'h0, d};
        if (d >= `VRSC_SIX_GAP_POS) begin
            u = u - `VRSC_SIX_GAP;
        end
        if (m == VRSC_MODE_FIVE_HI) begin
            u = `VRSC_FIVE_HI_BASE - {2'h0, c[4:0], 1'b0};
        end else if (m == VRSC_MODE_FIVE_LO) begin
            u = `VRSC_FIVE_LO_BASE - {2'h0, c[4:0], 1'b0};
        end
        return u;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [7:0] pin_s1_ff;
    logic [7:0] pin_s2_ff;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin_s1_ff <= 8'hff;
            pin_s2_ff <= 8'hff;
        end else begin
            pin_s1_ff <= {dac_mode_sel, voltage_id_inputs, half_step_select_bit};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    vrsc_mode_t mode;
    logic [5:0] pin_code;

    assign mode = mode_of(pin_s2_ff[7:6]);
    assign pin_code = (mode == VRSC_MODE_SIX) ? pin_s2_ff[5:0] : {1'b0, pin_s2_ff[5:1]};

    ////////////////////////////////////////////////////////////////////////
    // switching cycle and sample timing

    localparam logic [7:0] SW_LAST = 8'((`VRSC_SW_CYC) - 1);
    localparam logic [7:0] SAMPLE_LAST = 8'((`VRSC_SAMPLE_CYC) - 1);
    localparam logic [7:0] HALF_LAST = 8'((`VRSC_HALF_CYC) - 1);
    localparam logic [7:0] OFF_LAST = 8'((`VRSC_OFF_DELAY_CYC) - 1);

    logic [7:0] sub_cnt_ff;
    logic sample_tick;

    // six evenly spaced samples per switching cycle
    assign sample_tick = (sub_cnt_ff == SAMPLE_LAST);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sub_cnt_ff <= 8'h00;
        end else begin
            sub_cnt_ff <= sample_tick ? 8'h00 : sub_cnt_ff + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // code qualification

    logic new_valid;
    logic [5:0] new_code;
    logic [5:0] acc_code_ff;

    vrsc_code_filter i_vrsc_code_filter (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .sample_tick(sample_tick),
        .code_in(pin_code),
        .accepted_code(acc_code_ff),
        .new_valid(new_valid),
        .new_code(new_code)
    );

    logic new_off;
    logic [7:0] new_units;

    assign new_off = is_off(mode, new_code);
    assign new_units = code_units(mode, new_code);

    ////////////////////////////////////////////////////////////////////////
    // reference target and slewing

    vrsc_slew_t slew_ff;
    vrsc_slew_t nxt_slew;
    logic [7:0] goal_ff;
    logic [7:0] target_ff;
    logic [7:0] nxt_target;
    logic [7:0] nxt_goal;
    logic [7:0] slew_cnt_ff;
    logic [7:0] nxt_slew_cnt;
    logic slew_due;
    logic take_new;
    logic five_mode;
    logic busy_ff;

    assign slew_due = (slew_cnt_ff == 8'h00);
    assign take_new = new_valid && !new_off;
    assign five_mode = (mode != VRSC_MODE_SIX);

    always_comb begin
        nxt_slew = slew_ff;
        nxt_target = target_ff;
        nxt_goal = goal_ff;
        nxt_slew_cnt = (slew_cnt_ff == 8'h00) ? 8'h00 : slew_cnt_ff - 8'h01;
        if (take_new && !five_mode) begin
            nxt_target = new_units;
            nxt_goal = new_units;
            nxt_slew = VRSC_SLEW_IDLE;
        end else if (take_new) begin
            // any distance is taken, reached by single steps
            nxt_goal = new_units;
            nxt_slew_cnt = HALF_LAST;
            nxt_slew = VRSC_SLEW_WAIT;
        end else begin
            unique case (slew_ff)
                VRSC_SLEW_IDLE: begin
                    nxt_slew = VRSC_SLEW_IDLE;
                end
                VRSC_SLEW_WAIT, VRSC_SLEW_RUN: begin
                    if (slew_due) begin
                        // one 12.5mV unit per phase cycle
                        if (target_ff < goal_ff) begin
                            nxt_target = target_ff + 8'h01;
                        end else if (target_ff > goal_ff) begin
                            nxt_target = target_ff - 8'h01;
                        end
                        nxt_slew_cnt = SW_LAST;
                        nxt_slew = (nxt_target == goal_ff) ? VRSC_SLEW_IDLE : VRSC_SLEW_RUN;
                    end
                end
                default: begin
                    nxt_slew = VRSC_SLEW_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            slew_ff <= VRSC_SLEW_IDLE;
            target_ff <= `VRSC_TARGET_RST;
            goal_ff <= `VRSC_TARGET_RST;
            slew_cnt_ff <= 8'h00;
            busy_ff <= 1'b0;
        end else begin
            slew_ff <= nxt_slew;
            target_ff <= nxt_target;
            goal_ff <= nxt_goal;
            slew_cnt_ff <= nxt_slew_cnt;
            // registered copy so the busy output comes from a flip-flop
            busy_ff <= (nxt_slew != VRSC_SLEW_IDLE);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            acc_code_ff <= `VRSC_CODE_RST;
        end else if (new_valid) begin
            acc_code_ff <= new_code;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // no-load shutdown

    logic off_pend_ff;
    logic [7:0] off_cnt_ff;
    logic pwm_en_ff;
    logic ovp_sd_ff;
    logic off_done;

    assign off_done = off_pend_ff && (off_cnt_ff == 8'h00);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            off_pend_ff <= 1'b0;
            off_cnt_ff <= 8'h00;
            pwm_en_ff <= 1'b0;
            ovp_sd_ff <= 1'b1;
        end else if (new_valid && new_off) begin
            off_pend_ff <= 1'b1;
            off_cnt_ff <= OFF_LAST;
        end else if (take_new) begin
            off_pend_ff <= 1'b0;
            pwm_en_ff <= 1'b1;
            ovp_sd_ff <= 1'b0;
        end else if (off_done) begin
            off_pend_ff <= 1'b0;
            pwm_en_ff <= 1'b0;
            ovp_sd_ff <= 1'b1;
        end else if (off_pend_ff) begin
            off_cnt_ff <= off_cnt_ff - 8'h01;
        end
    end

    assign dac_target_voltage = target_ff;
    assign pwm_enable = pwm_en_ff;
    assign ovp_shutdown_level = ovp_sd_ff;
    assign slew_busy = busy_ff;
    assign accepted_code = acc_code_ff;

endmodule

// [pkg/vrsc_cfg.svh]
// constants for the reference slew control block
`ifndef VRSC_CFG_SVH
`define VRSC_CFG_SVH

`define VRSC_CLK_PERIOD_NS 50
`define VRSC_SW_PERIOD_NS 3000
`define VRSC_SW_CYC (`VRSC_SW_PERIOD_NS / `VRSC_CLK_PERIOD_NS)
`define VRSC_SAMPLES_PER_SW 6
`define VRSC_SAMPLE_CYC (`VRSC_SW_CYC / `VRSC_SAMPLES_PER_SW)
`define VRSC_HALF_CYC (`VRSC_SW_CYC / 2)
`define VRSC_QUAL_COUNT 2'h3
`define VRSC_OFF_DELAY_SW 2
`define VRSC_OFF_DELAY_CYC (`VRSC_OFF_DELAY_SW * `VRSC_SW_CYC)

`define VRSC_CODE_RST 6'h3f
`define VRSC_TARGET_RST 8'h00
`define VRSC_OFF_VID 5'h1f
`define VRSC_SIX_ORIGIN 6'h14
`define VRSC_SIX_BASE 8'h43
`define VRSC_SIX_GAP_POS 6'h17
`define VRSC_SIX_GAP 8'h02
`define VRSC_FIVE_HI_BASE 8'h94
`define VRSC_FIVE_LO_BASE 8'h7c

`endif

// [pkg/vrsc_pkg.sv]
// types for the reference slew control block
package vrsc_pkg;

    typedef enum logic [1:0] {
        VRSC_MODE_SIX,
        VRSC_MODE_FIVE_HI,
        VRSC_MODE_FIVE_LO
    } vrsc_mode_t;

    typedef enum logic [1:0] {
        VRSC_SLEW_IDLE,
        VRSC_SLEW_WAIT,
        VRSC_SLEW_RUN
    } vrsc_slew_t;

endpackage

// [rtl/vrsc_code_filter.sv]
// three-sample qualifier for the identification code
`timescale 1ns/1ps
`include "vrsc_cfg.svh"

module vrsc_code_filter
    import vrsc_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic sample_tick,
    input wire logic [5:0] code_in,
    input wire logic [5:0] accepted_code,
    output logic new_valid,
    output logic [5:0] new_code
);

    logic [5:0] last_ff;
    logic [1:0] run_ff;
    logic valid_ff;
    logic [5:0] code_ff;
    logic same;
    logic [1:0] nxt_run;
    logic hit;

    assign same = (code_in == last_ff);
    assign nxt_run = !same ? 2'h1 : (run_ff == `VRSC_QUAL_COUNT) ? run_ff : run_ff + 2'h1;
    // changed code seen on three successive samples
    assign hit = sample_tick && (nxt_run == `VRSC_QUAL_COUNT) && (code_in != accepted_code);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            last_ff <= `VRSC_CODE_RST;
            run_ff <= 2'h0;
            valid_ff <= 1'b0;
            code_ff <= `VRSC_CODE_RST;
        end else begin
            valid_ff <= hit;
            if (sample_tick) begin
                last_ff <= code_in;
                run_ff <= nxt_run;
            end
            if (hit) begin
                code_ff <= code_in;
            end
        end
    end

    assign new_valid = valid_ff;
    assign new_code = code_ff;

endmodule

// [dv/vrsc_checker_assertions.sv]
// concurrent checks on the reference slew control ports
`timescale 1ns/1ps
module vrsc_checker
    import vrsc_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [4:0] voltage_id_inputs,
    input wire logic half_step_select_bit,
    input wire logic [1:0] dac_mode_sel,
    input wire logic [7:0] dac_target_voltage,
    input wire logic pwm_enable,
    input wire logic ovp_shutdown_level,
    input wire logic slew_busy,
    input wire logic [5:0] accepted_code
);
    wire six = (dac_mode_sel == 2'h0) || (dac_mode_sel == 2'h3);
    wire is_off = six ? (accepted_code[5:1] == 5'h1f) : (accepted_code[4:0] == 5'h1f);
    wire [5:0] gap = 6'h14 - accepted_code;
    wire [7:0] six_val = 8'h43 + {2'h0, gap} - ((gap >= 6'h17) ? 8'h02 : 8'h00);
    logic [5:0] cnt_ff;
    // cycles since the slew started, restarted on a new code, or last stepped
    always_ff @(posedge core_clk) begin
        if (sys_rst || $rose(slew_busy) || $changed(dac_target_voltage)
            || ($changed(accepted_code) && !is_off)) begin
            cnt_ff <= 6'h00;
        end else if (cnt_ff != 6'h3f) begin
            cnt_ff <= cnt_ff + 6'h01;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    chk_reset_state: assert property (disable iff (1'b0) sys_rst |=>
        dac_target_voltage == 8'h00 && !pwm_enable && ovp_shutdown_level && !slew_busy
        && accepted_code == 6'h3f) else $error("reset state wrong");
    chk_six_jump: assert property (six && $stable(dac_mode_sel) && $changed(accepted_code)
        && !is_off |-> dac_target_voltage == six_val) else $error("six-bit target wrong");
    chk_step_size: assert property (!six && $changed(dac_target_voltage) |->
        dac_target_voltage == $past(dac_target_voltage) + 8'h01 ||
        dac_target_voltage == $past(dac_target_voltage) - 8'h01) else $error("step not one unit");
    chk_step_spacing: assert property (!six && $changed(dac_target_voltage) && $past(slew_busy)
        |-> cnt_ff == 6'h1d || cnt_ff == 6'h3b) else $error("slew step timing wrong");
    chk_busy_progress: assert property ($past(slew_busy) && slew_busy |-> cnt_ff <= 6'h3b)
        else $error("slew stalled");
    chk_off_delay: assert property ($fell(pwm_enable) |->
        $past(is_off, 120) && !$past(is_off, 121)) else $error("shutdown delay wrong");
    chk_ovp_pairs: assert property (pwm_enable != ovp_shutdown_level)
        else $error("trip level and pwm disagree");
    chk_restart_code: assert property ($rose(pwm_enable) |-> ##[0:1] !is_off)
        else $error("restart without valid code");
    chk_off_holds: assert property ($rose(is_off) && $stable(dac_mode_sel)
        |-> $stable(dac_target_voltage)) else $error("off code moved target");
endmodule
bind vid_reference_slew_control vrsc_checker i_vrsc_checker (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .voltage_id_inputs(voltage_id_inputs),
    .half_step_select_bit(half_step_select_bit),
    .dac_mode_sel(dac_mode_sel),
    .dac_target_voltage(dac_target_voltage),
    .pwm_enable(pwm_enable),
    .ovp_shutdown_level(ovp_shutdown_level),
    .slew_busy(slew_busy),
    .accepted_code(accepted_code)
);

// [dv/vrsc_cpu_model.sv]
// processor model driving the identification pins
`timescale 1ns/1ps
module vrsc_cpu_model (
    input wire logic core_clk,
    input wire logic single_step,
    input wire logic glitch,
    input wire logic [5:0] want_code,
    output logic [4:0] vid_pins,
    output logic half_pin
);
    logic [5:0] cur_ff = 6'h3f;
    int dwell_ff = 0;
    // one code step per dwell when stepping, else a direct jump
    always @(posedge core_clk) begin
        dwell_ff <= (dwell_ff == 79) ? 0 : dwell_ff + 1;
        if (dwell_ff == 79 && cur_ff != want_code) begin
            cur_ff <= !single_step ? want_code :
                (cur_ff < want_code ? cur_ff + 6'h01 : cur_ff - 6'h01);
        end
    end
    // glitch shows a short-lived inverted code
    assign {vid_pins, half_pin} = glitch ? ~cur_ff : cur_ff;
endmodule

// [dv/vid_reference_slew_control_bench.sv]
// self-checking bench for the reference slew control block
`timescale 1ns/1ps
module vid_reference_slew_control_bench;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] dac_mode_sel = 2'h0;
    logic [5:0] want_code = 6'h3f;
    logic single_step = 1'b0;
    logic glitch = 1'b0;
    logic sel_pwm = 1'b0;
    wire [4:0] vid_pins;
    wire half_pin;
    wire [7:0] dac_target_voltage;
    wire pwm_enable;
    wire ovp_shutdown_level;
    wire slew_busy;
    wire [5:0] accepted_code;
    wire [7:0] watch = sel_pwm ? {7'h00, pwm_enable} : dac_target_voltage;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    int t0;
    int t1;
    vid_reference_slew_control i_vid_reference_slew_control (.core_clk(core_clk),
        .sys_rst(sys_rst), .voltage_id_inputs(vid_pins), .half_step_select_bit(half_pin),
        .dac_mode_sel(dac_mode_sel), .dac_target_voltage(dac_target_voltage),
        .pwm_enable(pwm_enable), .ovp_shutdown_level(ovp_shutdown_level),
        .slew_busy(slew_busy), .accepted_code(accepted_code));
    vrsc_cpu_model i_vrsc_cpu_model (.core_clk(core_clk), .single_step(single_step),
        .glitch(glitch), .want_code(want_code), .vid_pins(vid_pins), .half_pin(half_pin));
    initial forever #25 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wait_val(input logic pwm_sel, input logic [7:0] exp, input int lim);
        int i;
        sel_pwm = pwm_sel;
        for (i = 0; i < lim && watch !== exp; i++) @(negedge core_clk);
        if (i == lim) begin
            n_mismatch++;
            final_report();
        end
    endtask
    task automatic next_step(output int t);
        logic [7:0] old;
        int i;
        old = dac_target_voltage;
        for (i = 0; i < 300 && dac_target_voltage === old; i++) @(negedge core_clk);
        if (i == 300) begin
            n_mismatch++;
            final_report();
        end
        t = cyc;
    endtask
    function automatic logic [7:0] u6(input logic [5:0] c);
        logic [5:0] d;
        d = 6'h14 - c;
        return 8'h43 + {2'h0, d} - ((d >= 6'h17) ? 8'h02 : 8'h00);
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        check(dac_target_voltage, 8'h00);
        check({7'h00, ovp_shutdown_level}, 8'h01);
        @(posedge core_clk);
        want_code <= 6'h14;
        wait_val(1'b0, u6(6'h14), 400);
        check({7'h00, pwm_enable}, 8'h01);
        @(posedge core_clk);
        single_step <= 1'b1;
        want_code <= 6'h10;
        wait_val(1'b0, u6(6'h10), 600);
        check({2'h0, accepted_code}, 8'h10);
        @(posedge core_clk);
        glitch <= 1'b1;
        repeat (12) @(posedge core_clk);
        glitch <= 1'b0;
        repeat (60) @(negedge core_clk);
        check({2'h0, accepted_code}, 8'h10);
        @(posedge core_clk);
        single_step <= 1'b0;
        dac_mode_sel <= 2'h3;
        want_code <= 6'h3d;
        wait_val(1'b0, 8'h58, 400);
        check(dac_target_voltage, u6(6'h3d));
        @(posedge core_clk);
        dac_mode_sel <= 2'h1;
        want_code <= 6'h38;
        wait_val(1'b0, 8'h5c, 800);
        check(dac_target_voltage, 8'h5c);
        @(posedge core_clk);
        want_code <= 6'h34;
        next_step(t0);
        next_step(t1);
        check(8'(t1 - t0), 8'h3c);
        wait_val(1'b0, 8'h60, 400);
        check({7'h00, slew_busy}, 8'h00);
        @(posedge core_clk);
        dac_mode_sel <= 2'h2;
        want_code <= 6'h30;
        wait_val(1'b0, 8'h4c, 2000);
        check(dac_target_voltage, 8'h4c);
        @(posedge core_clk);
        want_code <= 6'h3e;
        wait_val(1'b1, 8'h00, 400);
        check(dac_target_voltage, 8'h4c);
        check({7'h00, ovp_shutdown_level}, 8'h01);
        @(posedge core_clk);
        want_code <= 6'h3c;
        wait_val(1'b0, 8'h40, 1000);
        check({7'h00, pwm_enable}, 8'h01);
        final_report();
    end
endmodule
